// ---- design/dgd_consts.svh ----
// timing counts and field limits for the disk data sequencer
// assumes half-bit resolution: one count per servo clock edge
`ifndef DGD_CONSTS_SVH
`define DGD_CONSTS_SVH

// one byte is eight bit cells, two servo edges per cell
`define DGD_HALF_PER_BYTE 16
// largest programmable count of one header or data preamble field, in bytes (data_len is not clipped)
`define DGD_FIELD_MAX 32
// read gate after write gate point at sector start: 0.5 bit
`define DGD_HDR_RG_HALF 1
// write gate point inside the data preamble: 3 bits
`define DGD_DATA_WG_HALF 6
// read gate inside the data preamble: 11.5 bits (3 + 8.5)
`define DGD_DATA_RG_HALF 23

`endif

// ---- design/dgd_pkg.sv ----
// types shared by the sequencer and its pin synchroniser
// assumes dgd_consts.svh carries all numeric constants
package dgd_pkg;

  typedef enum logic [1:0] {
    DGD_OP_READ = 2'b00,
    DGD_OP_WRITE = 2'b01,
    DGD_OP_FORMAT = 2'b10
  } dgd_op_t;

  typedef enum logic [2:0] {
    DGD_IDLE = 3'b000,
    DGD_ARMED = 3'b001,
    DGD_HDR_PRE = 3'b010,
    DGD_HDR_ID = 3'b011,
    DGD_HDR_POST = 3'b100,
    DGD_DATA_PRE = 3'b101,
    DGD_DATA_BODY = 3'b110,
    DGD_GAP = 3'b111
  } dgd_state_t;

endpackage : dgd_pkg

// ---- design/dgd_sync_if.sv ----
// synchronised drive events handed from the pin stage to the sequencer
// assumes both ends run on mclk
`timescale 1ns/1ps
interface dgd_sync_if;
  logic servo_level;
  logic servo_rise;
  logic servo_fall;
  logic mark_rise;
  logic index_rise;

  modport src (output servo_level, output servo_rise, output servo_fall, output mark_rise, output index_rise);
  modport dst (input servo_level, input servo_rise, input servo_fall, input mark_rise, input index_rise);
endinterface : dgd_sync_if

// ---- design/dgd_sync.sv ----
// two-flop synchronisers and edge finders for the drive-side pins
// assumes servo clock, index and sector pulses are asynchronous to mclk
`timescale 1ns/1ps
module dgd_sync (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // drive pins
  input wire logic servo_clock,
  input wire logic index_pulse,
  input wire logic sector_pulse,
  // events to the sequencer
  dgd_sync_if.src ev
);
  import dgd_pkg::*;

  logic [2:0] meta;
  logic [2:0] stable;
  logic [2:0] prev;
  logic [2:0] next_meta;
  logic [2:0] next_stable;
  logic [2:0] next_prev;

  always_comb begin
    next_meta = {sector_pulse, index_pulse, servo_clock};
    next_stable = meta;
    next_prev = stable;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      meta <= 3'h0;
      stable <= 3'h0;
      prev <= 3'h0;
    end else begin
      meta <= next_meta;
      stable <= next_stable;
      prev <= next_prev;
    end
  end

  // edges are found on the second stage only, never on the first
  assign ev.servo_level = stable[0];
  assign ev.servo_rise = stable[0] & ~prev[0];
  assign ev.servo_fall = ~stable[0] & prev[0];
  assign ev.index_rise = stable[1] & ~prev[1];
  assign ev.mark_rise = (stable[1] & ~prev[1]) | (stable[2] & ~prev[2]);
endmodule : dgd_sync

// ---- design/dgd_sequencer.sv ----
// sector sequencer of the disk data controller: gates, write clock, nrz data
// assumes index/sector pulses already carry the external post_index_sector_gap
// delay, and that an outside mux feeds the controller its read clock
`timescale 1ns/1ps
`include "dgd_consts.svh"
module dgd_sequencer #(
  parameter int DATA_LEN_W = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // command
  input wire logic start,
  input wire dgd_pkg::dgd_op_t op,
  output logic busy,
  output logic done,
  // format fields, counts in bytes
  input wire logic [5:0] hdr_pre_len,
  input wire logic [5:0] hdr_id_len,
  input wire logic [5:0] hdr_post_len,
  input wire logic [5:0] data_pre_len,
  input wire logic [DATA_LEN_W-1:0] data_len,
  // field patterns and write data
  input wire logic [7:0] pre_pattern,
  input wire logic [7:0] id_pattern,
  input wire logic [7:0] gap_pattern,
  input wire logic [7:0] wr_byte,
  output logic byte_taken,
  // drive side
  input wire logic servo_clock,
  input wire logic index_pulse,
  input wire logic sector_pulse,
  output logic read_gate,
  output logic write_gate,
  output logic write_clock,
  output logic nrz_write_data
);
  import dgd_pkg::*;

  // the byte counter and gate compare widths are only checked for this span
  if (DATA_LEN_W < 6 || DATA_LEN_W > 24) begin : g_bad_width
    $error("DATA_LEN_W out of range");
  end

  dgd_sync_if ev ();

  dgd_sync u_sync (
    .mclk(mclk),
    .nrst(nrst),
    .servo_clock(servo_clock),
    .index_pulse(index_pulse),
    .sector_pulse(sector_pulse),
    .ev(ev)
  );

  // counts above the limit are clipped, zero is raised to one byte
  function automatic logic [DATA_LEN_W-1:0] field_len(input logic [5:0] len);
    logic [5:0] c;
    c = len;
    if (c > 6'(`DGD_FIELD_MAX)) c = 6'(`DGD_FIELD_MAX);
    if (c == 6'h0) c = 6'h1;
    field_len = DATA_LEN_W'(c);
  endfunction : field_len

  dgd_state_t state;
  dgd_state_t next_state;
  dgd_op_t cur_op;
  dgd_op_t next_cur_op;
  logic fmt_on;
  logic next_fmt_on;
  logic [3:0] half;
  logic [3:0] next_half;
  logic [DATA_LEN_W-1:0] nbyte;
  logic [DATA_LEN_W-1:0] next_nbyte;
  logic next_done;
  logic next_taken;
  logic [DATA_LEN_W-1:0] cur_len;
  logic last_byte;

  always_comb begin
    unique case (state)
      DGD_HDR_PRE: cur_len = field_len(hdr_pre_len);
      DGD_HDR_ID: cur_len = field_len(hdr_id_len);
      DGD_HDR_POST: cur_len = field_len(hdr_post_len);
      DGD_DATA_PRE: cur_len = field_len(data_pre_len);
      DGD_DATA_BODY: cur_len = (data_len == '0) ? DATA_LEN_W'(1) : data_len;
      default: cur_len = '1;
    endcase
    last_byte = (nbyte + DATA_LEN_W'(1) == cur_len);
  end

  always_comb begin
    next_state = state;
    next_cur_op = cur_op;
    next_fmt_on = fmt_on;
    next_half = half;
    next_nbyte = nbyte;
    next_done = 1'b0;
    next_taken = 1'b0;
    if (state == DGD_IDLE) begin
      if (start) begin
        next_cur_op = op;
        next_state = DGD_ARMED;
      end
    end else if (ev.mark_rise) begin
      if ((cur_op == DGD_OP_FORMAT && fmt_on && ev.index_rise) ||
          (cur_op != DGD_OP_FORMAT && state == DGD_GAP)) begin
        // format ends on the index after a full revolution
        next_state = DGD_IDLE;
        next_fmt_on = 1'b0;
        next_done = 1'b1;
      end else if (cur_op != DGD_OP_FORMAT || fmt_on || ev.index_rise) begin
        next_state = DGD_HDR_PRE;
        next_half = 4'h0;
        next_nbyte = '0;
        next_fmt_on = (cur_op == DGD_OP_FORMAT);
      end
    end else if (state != DGD_ARMED && (ev.servo_rise || ev.servo_fall)) begin
      next_half = half + 4'h1;
      if (half == 4'(`DGD_HALF_PER_BYTE - 1)) begin
        if (state == DGD_GAP) begin
          // gap runs on with no count until the next sector mark
          next_nbyte = nbyte;
        end else if (last_byte) begin
          next_nbyte = '0;
          next_taken = (state == DGD_DATA_BODY);
          unique case (state)
            DGD_HDR_PRE: next_state = DGD_HDR_ID;
            DGD_HDR_ID: next_state = DGD_HDR_POST;
            DGD_HDR_POST: next_state = DGD_DATA_PRE;
            DGD_DATA_PRE: next_state = DGD_DATA_BODY;
            default: next_state = DGD_GAP;
          endcase
        end else begin
          next_nbyte = nbyte + DATA_LEN_W'(1);
          next_taken = (state == DGD_DATA_BODY);
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state <= DGD_IDLE;
      cur_op <= DGD_OP_READ;
      fmt_on <= 1'b0;
      half <= 4'h0;
      nbyte <= '0;
      done <= 1'b0;
      byte_taken <= 1'b0;
    end else begin
      state <= next_state;
      cur_op <= next_cur_op;
      fmt_on <= next_fmt_on;
      half <= next_half;
      nbyte <= next_nbyte;
      done <= next_done;
      byte_taken <= next_taken;
    end
  end

  // gate and serial data group
  logic [DATA_LEN_W+3:0] pos;
  logic next_rg;
  logic next_wg;
  logic next_wclk;
  logic next_nrz;
  logic next_busy;
  logic [7:0] pattern;

  always_comb begin
    pos = {nbyte, half};
    next_rg = 1'b0;
    next_wg = 1'b0;
    next_busy = (state != DGD_IDLE);
    unique case (state)
      DGD_HDR_PRE, DGD_DATA_PRE: pattern = pre_pattern;
      DGD_HDR_ID: pattern = id_pattern;
      DGD_DATA_BODY: pattern = wr_byte;
      default: pattern = gap_pattern;
    endcase
    if (cur_op != DGD_OP_FORMAT) begin
      // header is read in read and write ops, not in format; half a bit after the write gate point
      if ((state == DGD_HDR_PRE && pos >= (DATA_LEN_W+4)'(`DGD_HDR_RG_HALF)) || state == DGD_HDR_ID) begin
        next_rg = 1'b1;
      end
    end
    if (cur_op == DGD_OP_READ) begin
      // 11.5 bits into the preamble keeps read gate clear of the splice byte
      if ((state == DGD_DATA_PRE && pos >= (DATA_LEN_W+4)'(`DGD_DATA_RG_HALF)) || state == DGD_DATA_BODY) begin
        next_rg = 1'b1;
      end
    end
    if (cur_op == DGD_OP_WRITE) begin
      if ((state == DGD_DATA_PRE && pos >= (DATA_LEN_W+4)'(`DGD_DATA_WG_HALF)) ||
          state == DGD_DATA_BODY || state == DGD_GAP) begin
        next_wg = 1'b1;
      end
    end
    if (cur_op == DGD_OP_FORMAT && fmt_on && next_state != DGD_IDLE) begin
      next_wg = 1'b1;
    end
    // data moves on the falling servo edge so it is settled at the rising one
    next_nrz = nrz_write_data;
    if (!next_wg) begin
      // data line rests low as soon as the gate drops, not at the next fall
      next_nrz = 1'b0;
    end else if (ev.servo_fall) begin
      next_nrz = pattern[3'h7 - half[3:1]];
    end
    next_wclk = ev.servo_level & next_wg;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      read_gate <= 1'b0;
      write_gate <= 1'b0;
      write_clock <= 1'b0;
      nrz_write_data <= 1'b0;
      busy <= 1'b0;
    end else begin
      read_gate <= next_rg;
      write_gate <= next_wg;
      write_clock <= next_wclk;
      nrz_write_data <= next_nrz;
      busy <= next_busy;
    end
  end
endmodule : dgd_sequencer

// ---- tb/dgd_drive.sv ----
// drive model: free-running servo clock, gap-delayed index and sector pulses
// assumes the sequencer watches only these three pins
`timescale 1ns/1ps
module dgd_drive #(
  parameter int SECT_CYC = 384,
  parameter int SECTS = 3,
  parameter int GAP_CYC = 8,
  parameter int ALT = 0
) (
  // drive pins
  output logic servo_clock,
  output logic index_pulse,
  output logic sector_pulse,
  // read path between controller and drive
  input logic read_gate,
  output logic read_gate_drive,
  output logic mux_clock
);
  int slot;
  int rg_cnt;
  int dly;
  int short_pulses = 0;
  int rd_passes = 0;
  logic lock_ok = 1'b0;
  logic sel_req = 1'b0;
  logic rc_shift;
  logic read_clock;
  logic [1:0] rd_en = 2'b00;
  logic [1:0] sv_en = 2'b00;
  realtime hi_t = 0.0;
  // read gate held back in servo bit times; alternative scheme only on marks
  initial begin
    read_gate_drive = 1'b0;
    rg_cnt = 0;
    dly = 8;
    forever begin
      @(posedge servo_clock);
      if (read_gate !== 1'b1) begin
        read_gate_drive = 1'b0;
        rg_cnt = 0;
      end else begin
        if (rg_cnt == 0) dly = (ALT == 0) ? 8 : ((index_pulse | sector_pulse) ? GAP_CYC : 0);
        if (rg_cnt >= dly) read_gate_drive = 1'b1;
        rg_cnt++;
      end
    end
  end
  // reference clock until lock, then a data-synchronous clock
  always @(posedge read_gate_drive) begin
    lock_ok = 1'b0;
    #2500;
    lock_ok = 1'b1;
  end
  assign #40 rc_shift = servo_clock;
  assign read_clock = (read_gate_drive && !lock_ok) ? servo_clock : rc_shift;
  // select lags read gate past the worst lock time
  always @(read_gate_drive) sel_req <= #3000 read_gate_drive;
  // each enable is synced on its own clock's fall, break before make
  always @(negedge read_clock) rd_en <= {rd_en[0], sel_req & !sv_en[1]};
  always @(negedge servo_clock) sv_en <= {sv_en[0], !sel_req & !rd_en[1]};
  assign mux_clock = (read_clock & rd_en[1]) | (servo_clock & sv_en[1]);
  always @(posedge mux_clock) begin
    hi_t = $realtime;
    if (rd_en[1]) rd_passes++;
  end
  always @(negedge mux_clock) if ($realtime - hi_t < 70.0) short_pulses++;
  // servo clock is available at all times, so it runs free; 6.25 MHz is under 25 MHz
  initial begin
    servo_clock = 1'b0;
    forever #80 servo_clock = ~servo_clock;
  end
  initial begin
    index_pulse = 1'b0;
    sector_pulse = 1'b0;
    slot = 0;
    forever begin
      // mark held back by the head scatter gap, counter reloaded each slot
      repeat (GAP_CYC) @(posedge servo_clock);
      #40;
      if (slot == 0) index_pulse = 1'b1;
      else sector_pulse = 1'b1;
      repeat (2) @(posedge servo_clock);
      #40;
      index_pulse = 1'b0;
      sector_pulse = 1'b0;
      repeat (SECT_CYC - GAP_CYC - 2) @(posedge servo_clock);
      slot = (slot + 1) % SECTS;
    end
  end
endmodule : dgd_drive

// ---- tb/dgd_monitor.sv ----
// checker for the sequencer gate points and write clock
// assumes it is bound to dgd_sequencer and sees only its ports
`timescale 1ns/1ps
`include "dgd_consts.svh"
module dgd_monitor (
  // clock, reset and command
  input wire logic mclk,
  input wire logic nrst,
  input wire logic start,
  input wire logic busy,
  input wire dgd_pkg::dgd_op_t op,
  // header field counts
  input wire logic [5:0] hdr_pre_len,
  input wire logic [5:0] hdr_id_len,
  input wire logic [5:0] hdr_post_len,
  // drive side
  input wire logic servo_clock,
  input wire logic index_pulse,
  input wire logic sector_pulse,
  input wire logic read_gate,
  input wire logic write_gate,
  input wire logic write_clock,
  input wire logic nrz_write_data
);
  import dgd_pkg::*;
  logic [2:0] sv;
  logic [2:0] mk;
  logic [11:0] ec;
  logic [11:0] hb;
  logic fmt;
  function automatic logic [11:0] clip(input logic [5:0] n);
    return (n == 6'h00) ? 12'h001 : ((n > 6'h20) ? 12'h020 : {6'h00, n});
  endfunction : clip
  assign hb = 12'((clip(hdr_pre_len) + clip(hdr_id_len) + clip(hdr_post_len)) * `DGD_HALF_PER_BYTE);
  // own servo edge count since the last mark, same sync depth as the design
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sv <= 3'h0;
      mk <= 3'h0;
      ec <= 12'h000;
      fmt <= 1'b0;
    end else begin
      sv <= {sv[1:0], servo_clock};
      mk <= {mk[1:0], index_pulse | sector_pulse};
      ec <= (mk[1] && !mk[2]) ? 12'h000 : ec + {11'h000, sv[1] ^ sv[2]};
      fmt <= (start && !busy) ? (op == DGD_OP_FORMAT) : fmt;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  hdr_rg_a: assert property ($rose(read_gate) && ec < hb |-> ec == `DGD_HDR_RG_HALF)
    else $error("header read gate off point");
  data_rg_a: assert property ($rose(read_gate) && ec >= hb |-> ec == hb + `DGD_DATA_RG_HALF)
    else $error("data read gate off point");
  data_wg_a: assert property ($rose(write_gate) && !fmt |-> ec == hb + `DGD_DATA_WG_HALF)
    else $error("write gate off point");
  gap_hold_a: assert property ($fell(write_gate) |-> $past(index_pulse | sector_pulse, 2))
    else $error("write gate dropped before mark");
  fmt_hold_a: assert property ($fell(write_gate) && fmt |-> $past(index_pulse, 2))
    else $error("format gate dropped off index");
  wc_off_a: assert property (!write_gate && !$past(write_gate) |-> !write_clock && !nrz_write_data)
    else $error("write clock or data while gate off");
  wc_follow_a: assert property ($rose(write_clock) && $past(write_gate, 2) |-> servo_clock && $past(servo_clock, 2))
    else $error("write clock not servo");
  nrz_fall_a: assert property ($changed(nrz_write_data) && write_gate && $past(write_gate)
    |-> !servo_clock && !$past(servo_clock, 2)) else $error("data moved off servo fall");
endmodule : dgd_monitor

// ---- tb/dgd_sequencer_test.sv ----
// bench for the sector sequencer with a drive model on its pins
// assumes dgd_drive and dgd_monitor are compiled before it
`timescale 1ns/1ps
module dgd_sequencer_test;
  import dgd_pkg::*;
  localparam int REV = 3 * 384 * 16;
  logic mclk, nrst, start, busy, done, byte_taken;
  dgd_op_t op;
  logic [5:0] hdr_pre_len, hdr_id_len, hdr_post_len, data_pre_len;
  logic [15:0] data_len;
  logic [7:0] pre_pattern, id_pattern, gap_pattern, wr_byte;
  logic servo_clock, index_pulse, sector_pulse, read_gate, write_gate, write_clock, nrz_write_data;
  int err_total, n_checks, n_rg, n_bt, wg_run, wg_max;
  dgd_sequencer uut (.mclk, .nrst, .start, .op, .busy, .done, .hdr_pre_len, .hdr_id_len, .hdr_post_len,
    .data_pre_len, .data_len, .pre_pattern, .id_pattern, .gap_pattern, .wr_byte, .byte_taken,
    .servo_clock, .index_pulse, .sector_pulse, .read_gate, .write_gate, .write_clock, .nrz_write_data);
  dgd_drive drv (.servo_clock, .index_pulse, .sector_pulse, .read_gate, .read_gate_drive(), .mux_clock());
  task automatic check(input bit ok, input string msg);
    n_checks++;
    if (!ok) begin
      err_total++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic run_op(input dgd_op_t o, input logic [5:0] p);
    int t;
    logic rq;
    t = 0;
    rq = 1'b0;
    n_rg = 0;
    n_bt = 0;
    wg_run = 0;
    wg_max = 0;
    @(posedge mclk);
    op <= o;
    hdr_pre_len <= p;
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    do begin
      @(posedge mclk);
      #1;
      if (read_gate === 1'b1 && rq !== 1'b1) n_rg++;
      rq = read_gate;
      if (byte_taken === 1'b1) n_bt++;
      wg_run = (write_gate === 1'b1) ? wg_run + 1 : 0;
      wg_max = (wg_run > wg_max) ? wg_run : wg_max;
      t++;
    end while (done !== 1'b1 && t < 50000);
    check(t < 50000, "no done");
    @(posedge mclk);
    #1;
    check(busy === 1'b0, "busy after done");
  endtask : run_op
  task automatic test_read;
    run_op(DGD_OP_READ, 6'h02);
    check(n_rg == 2, "read gate count");
    check(wg_max == 0, "write gate in read");
    check(drv.rd_passes > 0, "read clock never passed");
    check(drv.short_pulses == 0, "narrow mux pulse");
    $display("test_read done");
  endtask : test_read
  // started three clock cycles after the previous done
  task automatic test_write;
    wr_byte <= 8'ha5;
    gap_pattern <= 8'h4e;
    run_op(DGD_OP_WRITE, 6'h02);
    check(n_bt == 4, "byte count");
    check(n_rg == 1, "header read gate only");
    check(wg_max > 0, "no write gate");
    $display("test_write done");
  endtask : test_write
  // a header count above the limit is cut to 32 bytes
  task automatic test_clip;
    run_op(DGD_OP_READ, 6'h28);
    check(n_rg == 2, "clipped read");
    $display("test_clip done");
  endtask : test_clip
  task automatic test_format;
    run_op(DGD_OP_FORMAT, 6'h02);
    check(wg_max >= REV - 4 && wg_max <= REV + 4, "format gate span");
    check(n_rg == 0, "read gate in format");
    $display("test_format done");
  endtask : test_format
  task automatic complete_run;
    $display("checks %0d, errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    {nrst, start, err_total, n_checks} = '0;
    op = DGD_OP_READ;
    {hdr_pre_len, hdr_id_len, hdr_post_len, data_pre_len} = {6'h02, 6'h02, 6'h01, 6'h02};
    data_len = 16'h0004;
    // the sync byte is never all zeros
    {pre_pattern, id_pattern, gap_pattern, wr_byte} = 32'h00a1_4e3c;
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    test_read();
    test_write();
    test_clip();
    test_format();
    complete_run();
  end
  initial begin
    repeat (95000) @(posedge mclk);
    err_total++;
    complete_run();
  end
endmodule : dgd_sequencer_test
bind dgd_sequencer dgd_monitor mon (.mclk, .nrst, .start, .busy, .op, .hdr_pre_len, .hdr_id_len,
  .hdr_post_len, .servo_clock, .index_pulse, .sector_pulse, .read_gate, .write_gate, .write_clock,
  .nrz_write_data);
